// ==== hdl/ptm_pkg.sv ====
package ptm_pkg;
    // Word-aligned byte addresses on the AHB-Lite slave
    localparam logic [7:0] ADDR_RUN_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_OUTPUT_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_COUNTER_LOW = 8'h08;
    localparam logic [7:0] ADDR_COUNTER_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_COMPARE_A_LOW = 8'h10;
    localparam logic [7:0] ADDR_COMPARE_A_HIGH = 8'h14;
    localparam logic [7:0] ADDR_PERIOD_LOW = 8'h18;
    localparam logic [7:0] ADDR_PERIOD_HIGH = 8'h1C;
    localparam logic [7:0] ADDR_FLAGS = 8'h20;
    // Run control fields
    localparam int RUN_BIT = 3;
    localparam int PAUSE_BIT = 7;
    localparam int CLK_SEL_LSB = 4;
    // Output control fields
    localparam int CCLR_BIT = 0;
    localparam int RSVD_BIT = 1;
    localparam int INVERT_BIT = 2;
    localparam int INIT_LEVEL_BIT = 3;
    localparam int PIN_ACT_LSB = 4;
    localparam int MODE_LSB = 6;
    // Flag fields
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Counter tick prescale for the divided clock choices
    localparam int DIV4 = 4;
    localparam int DIV16 = 16;
    localparam int DIV64 = 64;
    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ==== hdl/ptm_timer.sv ====
`timescale 1ns/1ps
// Behaviour
// - compare mode pin starts at initial level
// - PWM polarity chosen by initial level
// - single pulse start sets initial level
// - timer mode ignores level and invert
// - invert flips output pin
// - clear select picks A or P/overflow
// - overflow clear only when period zero
// - PWM/single pulse ignore clear select
// - counter readable as two read-only bytes
// - compare A held in two RW bytes
// - period held in two RW bytes
// - unimplemented high bits read zero
// - four modes, 00 is compare mode
// - compare mode raises A and P flags
// - clear on A never raises P flag
// - zero compare A overflows, no A flag
// - in compare mode only A match moves the pin
// - A match drives high, low or toggle
// - run rising edge restores initial level
// - counter width 10 or 16 by instance
// - mode 10 PWM/pulse, 11 timer
// - pin action 01 low, 10 high, 11 toggle
// - run rise zeros counter, fall holds
// - pause holds counter value
module ptm_timer
    import ptm_pkg::*;
#(
    parameter int WIDTH = 10
) (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic EXT_CLK_PIN,
    output logic TIMER_OUTPUT_PIN,
    output logic MATCH_A_PULSE,
    output logic MATCH_P_PULSE
);
    localparam logic [WIDTH-1:0] MAXV = '1;

    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [7:0] run_ctl;
        logic [7:0] out_ctl;
        logic [WIDTH-1:0] count;
        logic [WIDTH-1:0] cmp_a;
        logic [WIDTH-1:0] period;
        logic [1:0] flags;
        logic pin;
        logic run_d;
        logic [5:0] div;
        logic [1:0] ext_sync;
        logic ext_d;
        logic pa;
        logic pp;
        logic [31:0] rdata;
    } ptm_state_s;

    ptm_state_s r;
    ptm_state_s next_r;

    function automatic logic [7:0] hi_byte(input logic [WIDTH-1:0] v);
        logic [15:0] w;
        w = 16'(v);
        return w[15:8];
    endfunction

    function automatic logic [WIDTH-1:0] put_byte(input logic [WIDTH-1:0] v,
                                                  input logic hi, input logic [7:0] b);
        logic [15:0] w;
        w = 16'(v);
        if (hi) begin
            w[15:8] = b;
        end else begin
            w[7:0] = b;
        end
        return w[WIDTH-1:0];
    endfunction

    logic [1:0] mode;
    logic [1:0] act;
    logic run;
    logic tick;
    logic [2:0] csel;
    logic match_a;
    logic match_p;
    logic at_max;
    logic clear;
    logic pin_raw;
    logic pwm_wave;
    logic acc;

    assign mode = r.out_ctl[MODE_LSB+:2];
    assign act = r.out_ctl[PIN_ACT_LSB+:2];
    assign run = r.run_ctl[RUN_BIT];
    assign csel = r.run_ctl[CLK_SEL_LSB+:3];
    assign acc = HSEL && HREADY && HTRANS == HTRANS_NONSEQ;

    always_comb begin
        unique case (csel)
            3'h0: tick = r.div[1:0] == 2'(DIV4 - 1);
            3'h1: tick = 1'b1;
            3'h2: tick = r.div[3:0] == 4'(DIV16 - 1);
            3'h3, 3'h4, 3'h5: tick = r.div == 6'(DIV64 - 1);
            3'h6: tick = r.ext_sync[1] && !r.ext_d;
            default: tick = !r.ext_sync[1] && r.ext_d;
        endcase
    end

    assign at_max = r.count == MAXV;
    assign match_a = tick && run && !r.run_ctl[PAUSE_BIT] && r.cmp_a != '0
        && r.count == r.cmp_a;
    assign match_p = tick && run && !r.run_ctl[PAUSE_BIT] && r.period != '0
        && r.count == r.period;
    assign pwm_wave = r.count < r.cmp_a;

    always_comb begin
        next_r = r;
        next_r.div = r.div + 6'h01;
        next_r.ext_sync = {r.ext_sync[0], EXT_CLK_PIN};
        next_r.ext_d = r.ext_sync[1];
        next_r.run_d = run;
        next_r.pa = 1'b0;
        next_r.pp = 1'b0;
        clear = 1'b0;
        if (mode == MODE_PWM) begin
            clear = match_p || (r.period == '0 && at_max && tick);
            if (act == ACT_TOGGLE && match_a) begin
                next_r.run_ctl[RUN_BIT] = 1'b0;
            end
        end else if (r.out_ctl[CCLR_BIT]) begin
            clear = match_a;
        end else begin
            clear = match_p || (r.period == '0 && at_max && tick);
        end
        if (run && !r.run_ctl[PAUSE_BIT] && tick) begin
            next_r.count = clear ? '0 : r.count + 1'b1;
        end
        if (match_a) begin
            next_r.flags[FLAG_A_BIT] = 1'b1;
            next_r.pa = 1'b1;
        end
        if (match_p && (mode == MODE_PWM || !r.out_ctl[CCLR_BIT])) begin
            next_r.flags[FLAG_P_BIT] = 1'b1;
            next_r.pp = 1'b1;
        end
        if (mode == MODE_COMPARE && match_a) begin
            unique case (act)
                ACT_LOW: next_r.pin = 1'b0;
                ACT_HIGH: next_r.pin = 1'b1;
                ACT_TOGGLE: next_r.pin = !r.pin;
                default: next_r.pin = r.pin;
            endcase
        end
        if (mode == MODE_PWM && act == ACT_TOGGLE && match_a) begin
            next_r.pin = !r.out_ctl[INIT_LEVEL_BIT];
        end
        if (run && !r.run_d) begin
            next_r.count = '0;
            next_r.pin = r.out_ctl[INIT_LEVEL_BIT];
        end
        // Write data phase follows the captured address phase
        next_r.wr_pend = acc && HWRITE;
        if (acc) begin
            next_r.wr_addr = HADDR[7:0];
        end
        if (r.wr_pend) begin
            unique case (r.wr_addr)
                ADDR_RUN_CONTROL: next_r.run_ctl = HWDATA[7:0] & 8'hF8;
                ADDR_OUTPUT_CONTROL: next_r.out_ctl = HWDATA[7:0];
                ADDR_COMPARE_A_LOW: next_r.cmp_a = put_byte(r.cmp_a, 1'b0, HWDATA[7:0]);
                ADDR_COMPARE_A_HIGH: next_r.cmp_a = put_byte(r.cmp_a, 1'b1, HWDATA[7:0]);
                ADDR_PERIOD_LOW: next_r.period = put_byte(r.period, 1'b0, HWDATA[7:0]);
                ADDR_PERIOD_HIGH: next_r.period = put_byte(r.period, 1'b1, HWDATA[7:0]);
                ADDR_FLAGS: begin
                    // Write one clears; a match in the same cycle wins
                    next_r.flags = (r.flags & ~HWDATA[1:0]) | {next_r.pp, next_r.pa};
                end
                default: next_r.flags = next_r.flags;
            endcase
        end
        next_r.rdata = 32'h0000_0000;
        if (acc && !HWRITE) begin
            unique case (HADDR[7:0])
                ADDR_RUN_CONTROL: next_r.rdata[7:0] = r.run_ctl;
                ADDR_OUTPUT_CONTROL: next_r.rdata[7:0] = r.out_ctl;
                ADDR_COUNTER_LOW: next_r.rdata[7:0] = r.count[7:0];
                ADDR_COUNTER_HIGH: next_r.rdata[7:0] = hi_byte(r.count);
                ADDR_COMPARE_A_LOW: next_r.rdata[7:0] = r.cmp_a[7:0];
                ADDR_COMPARE_A_HIGH: next_r.rdata[7:0] = hi_byte(r.cmp_a);
                ADDR_PERIOD_LOW: next_r.rdata[7:0] = r.period[7:0];
                ADDR_PERIOD_HIGH: next_r.rdata[7:0] = hi_byte(r.period);
                ADDR_FLAGS: next_r.rdata[1:0] = r.flags;
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Pin shaping by mode
    always_comb begin
        unique case (mode)
            MODE_PWM: begin
                unique case (act)
                    ACT_NONE: pin_raw = !r.out_ctl[INIT_LEVEL_BIT];
                    ACT_LOW: pin_raw = r.out_ctl[INIT_LEVEL_BIT];
                    ACT_HIGH: pin_raw = pwm_wave ? r.out_ctl[INIT_LEVEL_BIT]
                        : !r.out_ctl[INIT_LEVEL_BIT];
                    default: pin_raw = r.pin;
                endcase
            end
            MODE_TIMER: pin_raw = 1'b0;
            default: pin_raw = r.pin;
        endcase
    end

    assign TIMER_OUTPUT_PIN = mode == MODE_TIMER ? 1'b0
        : pin_raw ^ r.out_ctl[INVERT_BIT];
    assign HRDATA = r.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign MATCH_A_PULSE = r.pa;
    assign MATCH_P_PULSE = r.pp;

    a_pin_restart: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (run && !r.run_d) |=> r.pin == $past(r.out_ctl[INIT_LEVEL_BIT]))
        else $error("pin not restored on run rise");
    a_count_zero: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (run && !r.run_d) |=> r.count == '0)
        else $error("counter not zeroed on run rise");
    a_pause_hold: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (r.run_ctl[PAUSE_BIT] && r.run_d && run) |=> r.count == $past(r.count))
        else $error("counter moved while paused");
    a_no_p_flag: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (mode == MODE_COMPARE && r.out_ctl[CCLR_BIT]) |=> !r.pp)
        else $error("P flag with clear on A");
    a_zero_a_flag: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (r.cmp_a == '0 && !r.wr_pend) |=> !r.pa)
        else $error("A flag with zero compare");
    a_pin_a_only: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (mode == MODE_COMPARE && !match_a && !(run && !r.run_d)) |=> r.pin == $past(r.pin))
        else $error("pin moved without A match");
    a_invert_pin: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (mode == MODE_COMPARE) |-> TIMER_OUTPUT_PIN == (r.pin ^ r.out_ctl[INVERT_BIT]))
        else $error("pin polarity wrong");
    a_clear_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (mode == MODE_COMPARE && r.out_ctl[CCLR_BIT] && match_a && r.run_d)
        |=> r.count == '0)
        else $error("counter not cleared on A match");
    a_high_zero: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (WIDTH == 10 && $past(acc && !HWRITE && (HADDR[7:0] == ADDR_COUNTER_HIGH
            || HADDR[7:0] == ADDR_COMPARE_A_HIGH || HADDR[7:0] == ADDR_PERIOD_HIGH)))
        |-> HRDATA[7:2] == 6'h00)
        else $error("unimplemented high bits not zero");
    a_step_one: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (tick && run && r.run_d && !r.run_ctl[PAUSE_BIT] && !match_a && !match_p
         && !at_max && !r.wr_pend) |=> r.count == $past(r.count) + 1'b1)
        else $error("counter did not step");
    // Register reads and writes
    a_read_upper: assert property (@(posedge SYS_CLK) disable iff (RESET)
        HRDATA[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_count_read: assert property (@(posedge SYS_CLK) disable iff (RESET)
        $past(acc && !HWRITE && HADDR[7:0] == ADDR_COUNTER_LOW)
        |-> HRDATA[7:0] == $past(r.count[7:0]))
        else $error("counter low byte read wrong");
    a_count_high: assert property (@(posedge SYS_CLK) disable iff (RESET)
        $past(acc && !HWRITE && HADDR[7:0] == ADDR_COUNTER_HIGH)
        |-> HRDATA[7:0] == hi_byte($past(r.count)))
        else $error("counter high byte read wrong");
    a_cmp_hold: assert property (@(posedge SYS_CLK) disable iff (RESET)
        !r.wr_pend |=> r.cmp_a == $past(r.cmp_a))
        else $error("compare A changed without write");
    a_period_hold: assert property (@(posedge SYS_CLK) disable iff (RESET)
        !r.wr_pend |=> r.period == $past(r.period))
        else $error("period changed without write");
    a_cmp_write: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (r.wr_pend && r.wr_addr == ADDR_COMPARE_A_LOW)
        |=> r.cmp_a[7:0] == $past(HWDATA[7:0]))
        else $error("compare A low byte not written");
    a_period_write: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (r.wr_pend && r.wr_addr == ADDR_PERIOD_LOW)
        |=> r.period[7:0] == $past(HWDATA[7:0]))
        else $error("period low byte not written");
    // Flags and pulses follow the comparators
    a_flag_a_set: assert property (@(posedge SYS_CLK) disable iff (RESET)
        match_a |=> r.flags[FLAG_A_BIT])
        else $error("A flag not set on A match");
    a_flag_p_set: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (match_p && mode == MODE_COMPARE && !r.out_ctl[CCLR_BIT])
        |=> r.flags[FLAG_P_BIT])
        else $error("P flag not set on P match");
    a_pulse_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        match_a |=> MATCH_A_PULSE)
        else $error("A pulse missing");
    a_pulse_a_only: assert property (@(posedge SYS_CLK) disable iff (RESET)
        !match_a |=> !MATCH_A_PULSE)
        else $error("A pulse without A match");
    a_pulse_p_only: assert property (@(posedge SYS_CLK) disable iff (RESET)
        !match_p |=> !MATCH_P_PULSE)
        else $error("P pulse without P match");
    a_flag_a_keep: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (r.flags[FLAG_A_BIT] && !(r.wr_pend && r.wr_addr == ADDR_FLAGS))
        |=> r.flags[FLAG_A_BIT])
        else $error("A flag lost");
    a_flag_p_keep: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (r.flags[FLAG_P_BIT] && !(r.wr_pend && r.wr_addr == ADDR_FLAGS))
        |=> r.flags[FLAG_P_BIT])
        else $error("P flag lost");
    // Pin actions on an A match in compare mode, then PWM, timer and counter checks
    a_act_low: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (mode == MODE_COMPARE && match_a && r.run_d && act == ACT_LOW)
        |=> !r.pin)
        else $error("pin not driven low");
    a_act_high: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (mode == MODE_COMPARE && match_a && r.run_d && act == ACT_HIGH)
        |=> r.pin)
        else $error("pin not driven high");
    a_act_toggle: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (mode == MODE_COMPARE && match_a && r.run_d && act == ACT_TOGGLE)
        |=> r.pin != $past(r.pin))
        else $error("pin not toggled");
    a_act_none: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (mode == MODE_COMPARE && match_a && r.run_d && act == ACT_NONE)
        |=> r.pin == $past(r.pin))
        else $error("pin moved with no action");
    a_timer_pin: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (mode == MODE_TIMER) |-> !TIMER_OUTPUT_PIN)
        else $error("pin driven in timer mode");
    a_pwm_level: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (mode == MODE_PWM && act == ACT_HIGH) |-> TIMER_OUTPUT_PIN
        == ((pwm_wave ~^ r.out_ctl[INIT_LEVEL_BIT]) ^ r.out_ctl[INVERT_BIT]))
        else $error("PWM level wrong");
    a_pwm_clear: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (mode == MODE_PWM && match_p && r.run_d)
        |=> r.count == '0)
        else $error("PWM period did not clear counter");
    a_pulse_stop: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (mode == MODE_PWM && act == ACT_TOGGLE && match_a && !r.wr_pend)
        |=> !run)
        else $error("single pulse did not stop");
    a_pulse_end: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (mode == MODE_PWM && act == ACT_TOGGLE && match_a && r.run_d)
        |=> r.pin != $past(r.out_ctl[INIT_LEVEL_BIT]))
        else $error("single pulse trailing edge missing");
    a_fast_tick: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (csel == 3'h1) |-> tick)
        else $error("no tick at full rate");
    a_off_hold: assert property (@(posedge SYS_CLK) disable iff (RESET)
        !run |=> r.count == $past(r.count))
        else $error("counter moved while off");
    a_clear_p: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (mode == MODE_COMPARE && !r.out_ctl[CCLR_BIT] && match_p && r.run_d)
        |=> r.count == '0)
        else $error("counter not cleared on P match");
    a_wrap_clear: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (mode == MODE_COMPARE && !r.out_ctl[CCLR_BIT] && r.period == '0 && at_max
         && tick && run && r.run_d && !r.run_ctl[PAUSE_BIT]) |=> r.count == '0)
        else $error("counter not cleared on overflow");
endmodule // ptm_timer

// ==== bench/ptm_pin_load.sv ====
`timescale 1ns/1ps
module ptm_pin_load (
    input wire logic SYS_CLK,
    input wire logic TIMER_OUTPUT_PIN,
    output logic level
);
    // Receiving circuit: latches the pin once per clock
    initial level = 1'b0;
    always @(posedge SYS_CLK) begin
        level <= TIMER_OUTPUT_PIN;
    end
endmodule // ptm_pin_load

// ==== bench/ptm_tb_top.sv ====
`timescale 1ns/1ps
module periodic_timer_compare_match_tb_top;
    import ptm_pkg::*;
    logic SYS_CLK = 1'b0;
    logic RESET = 1'b1;
    logic HSEL = 1'b0;
    logic HWRITE = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [31:0] HWDATA = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic [31:0] HRDATA, hr;
    logic HREADYOUT, HRESP, pin, pa, pp, lvl;
    logic e;
    int err_count = 0;
    int samples_checked = 0;
    int na = 0;
    int np = 0;
    int s, t, mx;
    ptm_timer #(.WIDTH(10)) ptm_timer_i (.SYS_CLK(SYS_CLK), .RESET(RESET), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .EXT_CLK_PIN(1'b0), .TIMER_OUTPUT_PIN(pin), .MATCH_A_PULSE(pa), .MATCH_P_PULSE(pp));
    ptm_pin_load ptm_pin_load_i (.SYS_CLK(SYS_CLK), .TIMER_OUTPUT_PIN(pin), .level(lvl));
    initial begin
        forever #10 SYS_CLK = ~SYS_CLK;
    end
    always @(posedge SYS_CLK) begin
        na <= na + int'(pa);
        np <= np + int'(pp);
    end
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, x, g);
        end
    endtask
    task automatic rdy;
        int n;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 20);
        if (HREADYOUT !== 1'b1) begin
            err_count++;
            tally_and_finish;
        end
    endtask
    // One single transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        HSEL <= 1'b1;
        HADDR <= {24'h0, a};
        HTRANS <= HTRANS_NONSEQ;
        HWRITE <= w;
        rdy;
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= {24'h0, d};
        rdy;
        hr = HRDATA;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] x);
        bus(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), {24'h0, x}, hr);
    endtask
    task automatic set16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h04, v[15:8]);
    endtask
    task automatic wait_a;
        int n;
        n = na;
        repeat (200) if (na == n) @(posedge SYS_CLK);
        if (na == n) begin
            err_count++;
            tally_and_finish;
        end
    endtask
    initial begin
        repeat (20) @(posedge SYS_CLK);
        RESET <= 1'b0;
        @(posedge SYS_CLK);
        for (int i = 0; i < 10; i++) rdc(8'(i * 4), 8'h00);
        set16(ADDR_COMPARE_A_LOW, 16'hFFA5);
        set16(ADDR_PERIOD_LOW, 16'hFF5A);
        wr(ADDR_COUNTER_LOW, 8'h77);
        wr(8'h24, 8'h55);
        rdc(ADDR_COMPARE_A_HIGH, 8'h03);
        rdc(ADDR_PERIOD_LOW, 8'h5A);
        rdc(ADDR_PERIOD_HIGH, 8'h03);
        rdc(ADDR_COUNTER_LOW, 8'h00);
        rdc(8'h24, 8'h00);
        // Free count every cycle, cleared only at the top value
        set16(ADDR_COMPARE_A_LOW, 16'h03FF);
        wr(ADDR_OUTPUT_CONTROL, 8'h01);
        wr(ADDR_RUN_CONTROL, 8'h18);
        repeat (40) @(posedge SYS_CLK);
        bus(1'b0, ADDR_COUNTER_LOW, 8'h00);
        s = int'(hr);
        bus(1'b0, ADDR_COUNTER_LOW, 8'h00);
        chk("count step", 32'(s + 2), hr);
        wr(ADDR_RUN_CONTROL, 8'h98);
        bus(1'b0, ADDR_COUNTER_LOW, 8'h00);
        s = int'(hr);
        wr(ADDR_RUN_CONTROL, 8'h10);
        rdc(ADDR_COUNTER_LOW, 8'(s));
        wr(ADDR_RUN_CONTROL, 8'h18);
        repeat (2) @(posedge SYS_CLK);
        bus(1'b0, ADDR_COUNTER_LOW, 8'h00);
        chk("count restart", 32'h1, hr);
        set16(ADDR_PERIOD_LOW, 16'h0005);
        set16(ADDR_COMPARE_A_LOW, 16'h000A);
        for (int m = 0; m < 16; m++) begin
            wr(ADDR_RUN_CONTROL, 8'h10);
            wr(ADDR_OUTPUT_CONTROL, {2'h0, 2'(m), m[2], m[3], 2'h1});
            wr(ADDR_RUN_CONTROL, 8'h18);
            repeat (3) @(posedge SYS_CLK);
            chk("pin start", 32'(m[2] ^ m[3]), 32'(lvl));
            wait_a;
            repeat (3) @(posedge SYS_CLK);
            e = (m[1:0] == ACT_LOW) ? 1'b0 : (m[1:0] == ACT_HIGH) ? 1'b1 : m[2] ^ m[0];
            chk("pin match", 32'(e ^ m[3]), 32'(lvl));
        end
        chk("p pulses", 32'h0, 32'(np));
        wr(ADDR_RUN_CONTROL, 8'h10);
        wr(ADDR_OUTPUT_CONTROL, 8'h00);
        set16(ADDR_COMPARE_A_LOW, 16'h0008);
        set16(ADDR_PERIOD_LOW, 16'h0014);
        wr(ADDR_RUN_CONTROL, 8'h18);
        s = na;
        t = np;
        mx = 0;
        for (int k = 0; k < 24; k++) begin
            bus(1'b0, ADDR_COUNTER_LOW, 8'h00);
            if (int'(hr) > mx) mx = int'(hr);
        end
        chk("count top", 32'h1, 32'(mx > 8 && mx <= 20));
        chk("a pulses", 32'h1, 32'(na - s >= 2));
        chk("p pulses run", 32'h1, 32'(np - t >= 2));
        rdc(ADDR_FLAGS, 8'h03);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_RUN_CONTROL, 8'h10);
            wr(ADDR_OUTPUT_CONTROL, {MODE_PWM, 1'b1, m[1], m[0], 3'h0});
            wr(ADDR_RUN_CONTROL, 8'h18);
            repeat (3) @(posedge SYS_CLK);
            chk("pin pwm", 32'(m[0]), 32'(lvl));
        end
        wr(ADDR_RUN_CONTROL, 8'h10);
        wr(ADDR_OUTPUT_CONTROL, 8'hCC);
        set16(ADDR_COMPARE_A_LOW, 16'h0000);
        set16(ADDR_PERIOD_LOW, 16'h0000);
        wr(ADDR_RUN_CONTROL, 8'h18);
        s = na;
        repeat (1100) @(posedge SYS_CLK);
        chk("a at top", 32'h0, 32'(na - s));
        chk("pin timer", 32'h0, 32'(lvl));
        tally_and_finish;
    end
endmodule // periodic_timer_compare_match_tb_top
